// file: hdl/tecc_pkg.sv
package tecc_pkg;

  // bus geometry
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;

  // register word offsets
  localparam logic [AW-1:0] OFS_CNT    = 4'h0;
  localparam logic [AW-1:0] OFS_CCA    = 4'h1;
  localparam logic [AW-1:0] OFS_CCB    = 4'h2;
  localparam logic [AW-1:0] OFS_MODE   = 4'h3;
  localparam logic [AW-1:0] OFS_CCCTL  = 4'h4;
  localparam logic [AW-1:0] OFS_OUTCTL = 4'h5;
  localparam logic [AW-1:0] OFS_EDGE   = 4'h6;

  // counter limits
  localparam logic [DW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DW-1:0] CNT_MAX  = 16'hffff;
  localparam logic [DW-1:0] CNT_ONE  = 16'h0001;

  // prescaler terminal counts, clk/2, clk/4, clk/16
  localparam logic [3:0] DIV_LAST0 = 4'h1;
  localparam logic [3:0] DIV_LAST1 = 4'h3;
  localparam logic [3:0] DIV_LAST2 = 4'hf;

  typedef enum logic [1:0] {
    RUN_STOP      = 2'b00,
    RUN_FREE      = 2'b01,
    RUN_CLR_EDGE  = 2'b10,
    RUN_CLR_MATCH = 2'b11
  } tecc_run_t;

  typedef enum logic [1:0] {
    EDG_FALL = 2'b00,
    EDG_RISE = 2'b01,
    EDG_NONE = 2'b10,
    EDG_BOTH = 2'b11
  } tecc_edge_t;

  typedef enum logic [1:0] {
    CKS_DIV0 = 2'b00,
    CKS_DIV1 = 2'b01,
    CKS_DIV2 = 2'b10,
    CKS_EXT  = 2'b11
  } tecc_cks_t;

  // mode_control_reg: [3:2] run, [1] toggle on edge, [0] wrap_flag
  typedef struct packed {
    tecc_run_t run;
    logic      tog_edge;
    logic      wrap;
  } tecc_mode_t;

  // capcmp_control_reg: [2] cap b, [1] trigger select a, [0] cap a
  typedef struct packed {
    logic cap_b;
    logic trig_sel;
    logic cap_a;
  } tecc_ccctl_t;

  // output_control_reg: [2] one-shot trigger, [1] one-shot enable, [0] output enable
  typedef struct packed {
    logic os_trig;
    logic os_en;
    logic out_en;
  } tecc_outctl_t;

  // prescaler_edge_reg: [5:4] edge b, [3:2] edge a, [1:0] count clock
  typedef struct packed {
    tecc_edge_t edge_b;
    tecc_edge_t edge_a;
    tecc_cks_t  cks;
  } tecc_edgectl_t;

  typedef struct packed {
    logic          we;
    logic          re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } tecc_bus_t;

endpackage

// file: hdl/tecc_top.sv
// Contract
// (R1) 16-bit up-counter advances on each count clock while running.
// (R2) counter read holds count clock, returns instant value, loses no tick; a read burst holding more than three ticks loses counts.
// (R3) counter reads 0000H while run mode is 00.
// (R4) counter cleared by reset and when run mode becomes 00.
// (R5) clear-on-edge mode clears counter on edge_input_a valid edge.
// (R6) clear-on-match mode clears counter on match with capture_compare_a.
// (R7) one-shot mode clears counter on trigger bit or edge_input_a edge.
// (R8) counter read never captures into capture_compare_b.
// (R9) compare a matches continuously, raises match_a_irq, holds value.
// (R10) compare b matches continuously, raises match_b_irq.
// (R11) capture a latches on opposite edge of a or valid edge of b.
// (R12) capture b latches on valid edge of edge_input_a.
// (R13) both registers 16-bit words, reset to 0000H.
// (R14) software changes capture_compare_a only while stopped.
// (R15) software loads nonzero compare values.
// (R16) software picks edge_input_b or timer output for shared pin.
// (R17) capture coinciding with stop may hold undefined data.
// (R18) software stops timer before moving capture to compare mode.
// (R19) captured value stays until reset or software overwrite.
// (R20) register in compare mode ignores capture triggers.
// (R21) capture b ignores the capture a trigger select.
// (R22) opposite-phase capture raises no irq; edge b raises irq only.
// (R23) run mode: stop, free, clear on edge, clear on match.
// (R24) wrap_flag sets on FFFFH to 0000H; stop or write 0 clears.
// (R25) free-running mode wraps through zero, no clear on matches.
`timescale 1ns/1ns
`default_nettype none

module tecc_top #(
  parameter logic [3:0] DIV0 = tecc_pkg::DIV_LAST0, // prescaler step 0
  parameter logic [3:0] DIV1 = tecc_pkg::DIV_LAST1, // prescaler step 1
  parameter logic [3:0] DIV2 = tecc_pkg::DIV_LAST2  // prescaler step 2
) (
  input  wire logic                    clk,              // 100 MHz clock
  input  wire logic                    nrst,             // async reset
  input  wire tecc_pkg::tecc_bus_t     bus,              // register request
  output logic [tecc_pkg::DW-1:0]      rdata,            // read data
  input  wire logic                    edge_input_a,     // edge pin a
  input  wire logic                    edge_input_b,     // edge pin b
  output logic                         timer_output_pin, // timer out
  output logic                         timer_output_oe,  // shared pin drive
  output logic                         match_a_irq,      // irq a pulse
  output logic                         match_b_irq       // irq b pulse
);

  // ****************************************
  // helpers
  // ****************************************

  // valid edge of a stable level pair
  function automatic logic edge_hit(
    input tecc_pkg::tecc_edge_t sel,
    input logic                 now,
    input logic                 prev
  );
    case (sel)
      tecc_pkg::EDG_RISE: edge_hit = now & ~prev;
      tecc_pkg::EDG_FALL: edge_hit = ~now & prev;
      tecc_pkg::EDG_BOTH: edge_hit = now ^ prev;
      default:            edge_hit = 1'b0;
    endcase
  endfunction

  // edge opposite to a valid edge; both-edge has none
  function automatic tecc_pkg::tecc_edge_t edge_rev(
    input tecc_pkg::tecc_edge_t sel
  );
    case (sel)
      tecc_pkg::EDG_RISE: edge_rev = tecc_pkg::EDG_FALL;
      tecc_pkg::EDG_FALL: edge_rev = tecc_pkg::EDG_RISE;
      default:            edge_rev = tecc_pkg::EDG_NONE;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************

  logic [2:0]              sa_q, sb_q;
  logic                    la_q, lb_q, pa_q, pb_q;
  logic [3:0]              div_q;
  logic [tecc_pkg::DW-1:0] cnt_q, cnt_d, cca_q, ccb_q, rdata_q;
  logic [1:0]              hold_q;
  tecc_pkg::tecc_mode_t    mode_q;
  tecc_pkg::tecc_ccctl_t   ccctl_q;
  tecc_pkg::tecc_outctl_t  outctl_q;
  tecc_pkg::tecc_edgectl_t edgectl_q;
  logic                    out_q, irqa_q, irqb_q;

  // ****************************************
  // pin inputs
  // ****************************************

  // three-stage sync; level moves only when stages 2 and 3 agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sa_q <= '0;
      sb_q <= '0;
      la_q <= 1'b0;
      lb_q <= 1'b0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end
    else
    begin
      sa_q <= {sa_q[1:0], edge_input_a};
      sb_q <= {sb_q[1:0], edge_input_b};
      if (sa_q[1] == sa_q[2])
        la_q <= sa_q[2];
      if (sb_q[1] == sb_q[2])
        lb_q <= sb_q[2];
      pa_q <= la_q;
      pb_q <= lb_q;
    end
  end

  logic running, ea_valid, ea_rev, eb_valid;

  // edges count only while running, so a stopped timer sees nothing
  assign running  = mode_q.run != tecc_pkg::RUN_STOP;
  assign ea_valid = running & edge_hit(edgectl_q.edge_a, la_q, pa_q);
  assign ea_rev   = running & edge_hit(edge_rev(edgectl_q.edge_a), la_q, pa_q);
  assign eb_valid = running & edge_hit(edgectl_q.edge_b, lb_q, pb_q);

  // ****************************************
  // register decode
  // ****************************************

  logic wr_mode, wr_ccctl, wr_outctl, wr_edge, wr_cca, wr_ccb, cnt_rd, os_set;

  assign wr_mode   = bus.we & (bus.addr == tecc_pkg::OFS_MODE);
  assign wr_ccctl  = bus.we & (bus.addr == tecc_pkg::OFS_CCCTL);
  assign wr_outctl = bus.we & (bus.addr == tecc_pkg::OFS_OUTCTL);
  assign wr_edge   = bus.we & (bus.addr == tecc_pkg::OFS_EDGE);
  assign wr_cca    = bus.we & (bus.addr == tecc_pkg::OFS_CCA);
  assign wr_ccb    = bus.we & (bus.addr == tecc_pkg::OFS_CCB);
  assign cnt_rd    = bus.re & (bus.addr == tecc_pkg::OFS_CNT);

  // trigger bit is a write-one strobe, it never stores
  assign os_set = wr_outctl & running & bus.wdata[2]; // R7

  // ****************************************
  // prescaler
  // ****************************************

  logic [3:0] div_last;
  logic       div_tick, cnt_tick;

  always_comb
  begin
    case (edgectl_q.cks)
      tecc_pkg::CKS_DIV0: div_last = DIV0;
      tecc_pkg::CKS_DIV1: div_last = DIV1;
      default:            div_last = DIV2;
    endcase
  end

  // divider restarts on stop so the first tick is a full period
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_q <= '0;
    else if (!running || div_q >= div_last)
      div_q <= '0;
    else
      div_q <= div_q + 4'h1;
  end

  assign div_tick = running & (div_q >= div_last);
  assign cnt_tick = (edgectl_q.cks == tecc_pkg::CKS_EXT) ? ea_valid : div_tick;

  // ****************************************
  // counter
  // ****************************************

  logic adv_req, adv, clr_evt, eq_a, wrap_set;

  // a tick seen during a counter read is kept pending, not dropped
  assign adv_req = running & (cnt_tick | (hold_q != 2'h0)); // R1
  assign adv     = adv_req & ~cnt_rd;              // R2
  assign eq_a    = cnt_q == cca_q;

  // external clears restart the count from zero
  assign clr_evt = ((mode_q.run == tecc_pkg::RUN_CLR_EDGE) & ea_valid) // R5
                 | (outctl_q.os_en & (os_set | ea_valid));              // R7

  always_comb
  begin
    cnt_d = cnt_q;
    if (!running)
      cnt_d = tecc_pkg::CNT_ZERO; // R4
    else if (clr_evt)
      cnt_d = tecc_pkg::CNT_ZERO;
    else if (adv)
    begin
      if ((mode_q.run == tecc_pkg::RUN_CLR_MATCH) && eq_a)
        cnt_d = tecc_pkg::CNT_ZERO; // R6
      else
        cnt_d = cnt_q + tecc_pkg::CNT_ONE; // R25
    end
  end

  // wrap counts in every running mode
  assign wrap_set = adv & ~clr_evt & (cnt_q == tecc_pkg::CNT_MAX); // R24

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= tecc_pkg::CNT_ZERO; // R4
    else
      cnt_q <= cnt_d;
  end

  // pending ticks from read cycles; a read burst stacking more than three loses counts
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hold_q <= '0;
    else if (!running)
      hold_q <= '0;
    else
      hold_q <= hold_q + {1'b0, cnt_tick} - {1'b0, adv}; // R2
  end

  // ****************************************
  // control registers
  // ****************************************

  // wrap flag: hardware set beats a software clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_q <= '0;
    else
    begin
      if (wr_mode)
      begin
        mode_q.run      <= tecc_pkg::tecc_run_t'(bus.wdata[3:2]); // R23
        mode_q.tog_edge <= bus.wdata[1];
      end
      if (wrap_set)
        mode_q.wrap <= 1'b1; // R24
      else if (!running)
        mode_q.wrap <= 1'b0;
      else if (wr_mode)
        mode_q.wrap <= bus.wdata[0];
    end
  end

  // mode select, output control and edge selection; trigger bit reads back zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ccctl_q   <= '0;
      outctl_q  <= '0;
      edgectl_q <= '0;
    end
    else
    begin
      if (wr_ccctl)
        ccctl_q <= bus.wdata[2:0];
      if (wr_outctl)
        outctl_q <= {1'b0, bus.wdata[1:0]};
      if (wr_edge)
        edgectl_q <= bus.wdata[5:0];
    end
  end

  // ****************************************
  // capture / compare
  // ****************************************

  logic cap_a, cap_b, cmp_a, cmp_b;

  // capture triggers are gated off in compare mode
  assign cap_a = ccctl_q.cap_a & (ccctl_q.trig_sel ? ea_rev : eb_valid); // R11 R20
  assign cap_b = ccctl_q.cap_b & ea_valid; // R12 R21 R8
  // compare hits are taken on the step into the matching value
  assign cmp_a = adv & ~ccctl_q.cap_a & (cnt_d == cca_q); // R9
  assign cmp_b = adv & ~ccctl_q.cap_b & (cnt_d == ccb_q); // R10

  // register a; a software write wins over a capture
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cca_q <= tecc_pkg::CNT_ZERO; // R13
    else if (wr_cca)
      cca_q <= bus.wdata;
    else if (cap_a)
      cca_q <= cnt_q; // R19 R17
  end

  // register b
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ccb_q <= tecc_pkg::CNT_ZERO; // R13
    else if (wr_ccb)
      ccb_q <= bus.wdata;
    else if (cap_b)
      ccb_q <= cnt_q;
  end

  // irq a: compare hit, b-edge capture, or b-edge alone in reverse phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqa_q <= 1'b0;
      irqb_q <= 1'b0;
    end
    else
    begin
      irqa_q <= cmp_a | (ccctl_q.cap_a & eb_valid); // R22
      irqb_q <= cmp_b | cap_b;
    end
  end

  // ****************************************
  // timer output and read port
  // ****************************************

  // toggle on either match; idle low while stopped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      out_q <= 1'b0;
    else if (!running)
      out_q <= 1'b0;
    else if (cmp_a | cmp_b | (mode_q.tog_edge & ea_valid))
      out_q <= ~out_q;
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= '0;
    else if (!bus.re)
      rdata_q <= '0;
    else if (bus.addr == tecc_pkg::OFS_CNT)
      rdata_q <= running ? cnt_q : tecc_pkg::CNT_ZERO; // R3
    else if (bus.addr == tecc_pkg::OFS_CCA)
      rdata_q <= cca_q;
    else if (bus.addr == tecc_pkg::OFS_CCB)
      rdata_q <= ccb_q;
    else if (bus.addr == tecc_pkg::OFS_MODE)
      rdata_q <= {12'h000, mode_q};
    else if (bus.addr == tecc_pkg::OFS_CCCTL)
      rdata_q <= {13'h0000, ccctl_q};
    else if (bus.addr == tecc_pkg::OFS_OUTCTL)
      rdata_q <= {13'h0000, outctl_q};
    else if (bus.addr == tecc_pkg::OFS_EDGE)
      rdata_q <= {10'h000, edgectl_q};
    else
      rdata_q <= '0;
  end

  assign rdata            = rdata_q;
  assign timer_output_pin = out_q;
  assign timer_output_oe  = outctl_q.out_en; // R16
  assign match_a_irq      = irqa_q;
  assign match_b_irq      = irqb_q;

endmodule

`default_nettype wire

// file: tb/tecc_props.sv
`timescale 1ns/1ns
`default_nettype none
// ******
// port checker
// ******
module tecc_props (
  input wire logic                    clk,             // clock
  input wire logic                    nrst,            // async reset
  input wire tecc_pkg::tecc_bus_t     bus,             // register request
  input wire logic [tecc_pkg::DW-1:0] rdata,           // read data
  input wire logic                    timer_output_oe, // shared pin drive
  input wire logic                    match_a_irq,     // irq a
  input wire logic                    match_b_irq      // irq b
);
  logic [3:0]  mode_q;
  logic        va_q;
  logic        vb_q;
  logic [15:0] sa_q;
  logic [15:0] sb_q;
  logic        rdc_q;
  logic        rdc2_q;
  logic [15:0] last_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // mirror of the mode field as software last wrote it
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) mode_q <= 4'h0;
    else if (bus.we && bus.addr == tecc_pkg::OFS_MODE) mode_q <= bus.wdata[3:0];

  // shadow of a; invalid once capture mode may have overwritten it
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      va_q <= 1'b1;
      sa_q <= 16'h0000;
    end
    else if (bus.we && bus.addr == tecc_pkg::OFS_CCA)
    begin
      va_q <= 1'b1;
      sa_q <= bus.wdata;
    end
    else if (bus.we && bus.addr == tecc_pkg::OFS_CCCTL && bus.wdata[0]) va_q <= 1'b0;

  // shadow of b, same scheme
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      vb_q <= 1'b1;
      sb_q <= 16'h0000;
    end
    else if (bus.we && bus.addr == tecc_pkg::OFS_CCB)
    begin
      vb_q <= 1'b1;
      sb_q <= bus.wdata;
    end
    else if (bus.we && bus.addr == tecc_pkg::OFS_CCCTL && bus.wdata[2]) vb_q <= 1'b0;

  // back-to-back counter reads in free-running mode
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rdc_q  <= 1'b0;
      rdc2_q <= 1'b0;
      last_q <= 16'h0000;
    end
    else
    begin
      rdc_q  <= bus.re && bus.addr == tecc_pkg::OFS_CNT && mode_q[3:2] == 2'b01;
      rdc2_q <= rdc_q;
      last_q <= rdata;
    end

  property p_cnt_stopped;
    bus.re && bus.addr == tecc_pkg::OFS_CNT && mode_q[3:2] == 2'b00 |=> rdata == 16'h0000;
  endproperty
  a_cnt_stopped: assert property (p_cnt_stopped) else $error("counter read nonzero while stopped");
  property p_oe;
    bus.we && bus.addr == tecc_pkg::OFS_OUTCTL |=> timer_output_oe == $past(bus.wdata[0]);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable does not follow its bit");
  property p_quiet;
    (mode_q[3:2] == 2'b00) [*3] |-> !match_a_irq && !match_b_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq while stopped");
  property p_wrap_stop;
    bus.re && bus.addr == tecc_pkg::OFS_MODE && mode_q == 4'h0 |=> rdata[3:0] == 4'h0;
  endproperty
  a_wrap_stop: assert property (p_wrap_stop) else $error("wrap flag set while stopped");
  property p_cca_hold;
    bus.re && bus.addr == tecc_pkg::OFS_CCA && va_q |=> rdata == sa_q;
  endproperty
  a_cca_hold: assert property (p_cca_hold) else $error("compare value a changed");
  property p_ccb_hold;
    bus.re && bus.addr == tecc_pkg::OFS_CCB && vb_q |=> rdata == sb_q;
  endproperty
  a_ccb_hold: assert property (p_ccb_hold) else $error("compare value b changed");
  property p_cnt_step;
    rdc_q && rdc2_q |-> 16'(rdata - last_q) <= 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter jumped between reads");
  property p_rd_idle;
    !bus.re |=> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

  c_irq_a: cover property (match_a_irq);
  c_irq_b: cover property (match_b_irq);
  c_step: cover property (rdc_q && rdc2_q);
endmodule

bind tecc_top tecc_props u_props (
  .clk             (clk),
  .nrst            (nrst),
  .bus             (bus),
  .rdata           (rdata),
  .timer_output_oe (timer_output_oe),
  .match_a_irq     (match_a_irq),
  .match_b_irq     (match_b_irq)
);
`default_nettype wire

// file: tb/tecc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ******
// edge sources and shared pin
// ******
module tecc_pin_model (
  input wire logic clk,              // clock
  input wire logic timer_output_pin, // timer drive level
  input wire logic timer_output_oe,  // timer owns shared pin
  output logic     edge_input_a,     // source a
  output logic     edge_input_b      // shared pin level
);
  logic a_q;
  logic b_q;

  initial
  begin
    a_q = 1'b0;
    b_q = 1'b0;
  end

  // one owner at a time on the shared pin, the timer wins when enabled
  assign edge_input_b = timer_output_oe ? timer_output_pin : b_q;
  assign edge_input_a = a_q;

  // pulse of w clocks; the sync filter sees it only when w is at least 2
  task automatic pulse(input bit sel, input int w);
    @(posedge clk);
    if (sel) b_q <= 1'b1;
    else a_q <= 1'b1;
    repeat (w) @(posedge clk);
    if (sel) b_q <= 1'b0;
    else a_q <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_timer_event_counter_capcmp.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_timer_event_counter_capcmp;
  logic                clk;
  logic                nrst;
  tecc_pkg::tecc_bus_t bus;
  logic [15:0]         rdata;
  logic                edge_input_a;
  logic                edge_input_b;
  logic                timer_output_pin;
  logic                timer_output_oe;
  logic                match_a_irq;
  logic                match_b_irq;
  int                  mismatches;
  int                  check_count;
  logic [15:0]         v;
  logic [15:0]         w;

  tecc_top dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .edge_input_a(edge_input_a),
    .edge_input_b(edge_input_b), .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
  tecc_pin_model pins (.clk(clk), .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .edge_input_a(edge_input_a), .edge_input_b(edge_input_b));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ******
  // bus cycles and waits
  // ******
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.we <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.re <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.re <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded wait, a pulse is only one cycle wide so poll every cycle
  task automatic wait_irq(input bit b);
    int n;
    n = 0;
    while (n < 200 && (b ? match_b_irq : match_a_irq) !== 1'b1)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 200)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t irq wait ran out", $time);
      final_report();
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ******
  // scenarios
  // ******
  task automatic t_reset;
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v, 16'h0000)
    rd(tecc_pkg::OFS_CCA, v);
    `CHK(v, 16'h0000)
    rd(tecc_pkg::OFS_CCB, v);
    `CHK(v, 16'h0000)
    rd(4'hf, v);
    `CHK(v, 16'h0000)
    $display("test reset done");
  endtask

  // two reads with no gap, then stop clears
  task automatic t_free;
    wr(tecc_pkg::OFS_MODE, 16'h0004);
    repeat (20) @(posedge clk);
    @(posedge clk);
    bus.re <= 1'b1;
    bus.addr <= tecc_pkg::OFS_CNT;
    @(posedge clk);
    #1 v = rdata;
    @(posedge clk);
    bus.re <= 1'b0;
    #1 w = rdata;
    `CHK(v, 16'h000a)
    `CHK(16'(w - v) <= 16'h0001, 1'b1)
    // the tick held by the two reads must come back later, not vanish
    repeat (4) @(posedge clk);
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v, 16'h000e)
    wr(tecc_pkg::OFS_MODE, 16'h0000);
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v, 16'h0000)
    rd(tecc_pkg::OFS_MODE, v);
    `CHK(v, 16'h0000)
    $display("test free done");
  endtask

  task automatic t_compare;
    wr(tecc_pkg::OFS_CCA, 16'h0009);
    wr(tecc_pkg::OFS_CCB, 16'h0005);
    wr(tecc_pkg::OFS_MODE, 16'h0004);
    wait_irq(1'b1);
    `CHK(timer_output_pin, 1'b1)
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v >= 16'h0005 && v <= 16'h0006, 1'b1)
    wait_irq(1'b0);
    `CHK(timer_output_pin, 1'b0)
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v >= 16'h0009 && v <= 16'h000a, 1'b1)
    pins.pulse(1'b0, 12);
    rd(tecc_pkg::OFS_CCB, v);
    `CHK(v, 16'h0005)
    rd(tecc_pkg::OFS_CCA, v);
    `CHK(v, 16'h0009)
    wr(tecc_pkg::OFS_MODE, 16'h0000);
    $display("test compare done");
  endtask

  // highest value seen must be the compare value itself
  task automatic t_match;
    wr(tecc_pkg::OFS_CCA, 16'h0004);
    wr(tecc_pkg::OFS_MODE, 16'h000c);
    w = 16'h0000;
    repeat (12)
    begin
      rd(tecc_pkg::OFS_CNT, v);
      if (v > w) w = v;
    end
    `CHK(w, 16'h0004)
    wr(tecc_pkg::OFS_MODE, 16'h0000);
    $display("test match done");
  endtask

  // rising edges on both pins, both registers capturing
  task automatic t_edge;
    wr(tecc_pkg::OFS_CCCTL, 16'h0005);
    wr(tecc_pkg::OFS_EDGE, 16'h0014);
    wr(tecc_pkg::OFS_MODE, 16'h0008);
    repeat (40) @(posedge clk);
    pins.pulse(1'b0, 12);
    rd(tecc_pkg::OFS_CCB, v);
    `CHK(v >= 16'h0010 && v <= 16'h001c, 1'b1)
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v <= 16'h0008, 1'b1)
    pins.pulse(1'b1, 12);
    rd(tecc_pkg::OFS_CCA, v);
    `CHK(v >= 16'h0004 && v <= 16'h0010, 1'b1)
    wr(tecc_pkg::OFS_MODE, 16'h0000);
    wr(tecc_pkg::OFS_CCCTL, 16'h0000);
    wr(tecc_pkg::OFS_CCA, 16'h0004);
    $display("test edge done");
  endtask

  task automatic t_oneshot;
    wr(tecc_pkg::OFS_OUTCTL, 16'h0003);
    #1;
    `CHK(timer_output_oe, 1'b1)
    wr(tecc_pkg::OFS_MODE, 16'h0004);
    repeat (30) @(posedge clk);
    wr(tecc_pkg::OFS_OUTCTL, 16'h0007);
    rd(tecc_pkg::OFS_CNT, v);
    `CHK(v <= 16'h0002, 1'b1)
    wr(tecc_pkg::OFS_MODE, 16'h0000);
    $display("test oneshot done");
  endtask

  // main sequence
  initial
  begin
    bus = '0;
    nrst = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_free();
    t_compare();
    t_match();
    t_edge();
    t_oneshot();
    final_report();
  end
endmodule
`default_nettype wire
